// ### inc/dcs_pkg.sv
// constants shared by the synthesizer core files
package dcs_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL1 = 8'h00;
  localparam logic [7:0] IDX_CTRL2 = 8'h01;
  localparam logic [7:0] IDX_TUNE = 8'h04;
  localparam logic [7:0] IDX_UPDATE = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h09;
  localparam logic [7:0] IDX_PHASE = 8'h0A;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL1_BUF_RST = 32'h00000000;
  localparam logic [31:0] CTRL1_ACT_RST = 32'h00000400;
  localparam logic [31:0] CTRL2_RST = 32'h00180000;
  localparam logic [31:0] TUNE_RST = 32'h00000000;
  localparam logic [31:0] PHASE_RST = 32'h00000000;

  // ---------------------------------------------------------------
  // field positions and limits
  // ---------------------------------------------------------------
  localparam int CLK_OFF_BIT = 4;
  localparam int CLR_PHASE_BIT = 10;
  localparam int XTAL_OUT_BIT = 9;
  localparam int MULT_LSB = 3;
  localparam int MULT_W = 5;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  localparam int UPDATE_BIT = 0;
  localparam int PHASE_W = 32;
  localparam int SAMPLE_W = 10;
  localparam int LUT_IDX_W = 5;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------
  localparam int ST_CLEAR = 0;
  localparam int ST_MULT_EN = 1;
  localparam int ST_RUN = 2;
  localparam int ST_OSC = 3;
  localparam int ST_XTAL = 4;

endpackage

// ### design/dcs_cosine.sv
// cosine map from accumulator phase to offset-binary sample
`timescale 1ns/1ps
module dcs_cosine
  import dcs_pkg::*;
(
  // phase input: quadrant and quarter-wave index
  input wire logic [LUT_IDX_W+1:0] phase_top,
  // amplitude output
  output logic [SAMPLE_W-1:0] amplitude
);

  // ---------------------------------------------------------------
  // quarter-wave table
  // ---------------------------------------------------------------
  // magnitude of cosine for the first quarter, full scale 511
  function automatic logic [8:0] quarter_cos(
    input logic [LUT_IDX_W-1:0] idx
  );
    logic [8:0] m;
    m = 9'h000;
    case (idx)
      5'h00: m = 9'h1FF; 5'h01: m = 9'h1FE;
      5'h02: m = 9'h1FD; 5'h03: m = 9'h1F9;
      5'h04: m = 9'h1F5; 5'h05: m = 9'h1F0;
      5'h06: m = 9'h1E9; 5'h07: m = 9'h1E1;
      5'h08: m = 9'h1D8; 5'h09: m = 9'h1CE;
      5'h0A: m = 9'h1C3; 5'h0B: m = 9'h1B6;
      5'h0C: m = 9'h1A9; 5'h0D: m = 9'h19A;
      5'h0E: m = 9'h18B; 5'h0F: m = 9'h17B;
      5'h10: m = 9'h169; 5'h11: m = 9'h157;
      5'h12: m = 9'h144; 5'h13: m = 9'h130;
      5'h14: m = 9'h11C; 5'h15: m = 9'h107;
      5'h16: m = 9'h0F1; 5'h17: m = 9'h0DA;
      5'h18: m = 9'h0C4; 5'h19: m = 9'h0AC;
      5'h1A: m = 9'h094; 5'h1B: m = 9'h07C;
      5'h1C: m = 9'h064; 5'h1D: m = 9'h04B;
      5'h1E: m = 9'h032; 5'h1F: m = 9'h019;
      default: m = 9'h000;
    endcase
    return m;
  endfunction

  // ---------------------------------------------------------------
  // quadrant folding
  // ---------------------------------------------------------------
  // mirror index in odd quadrants, negate in middle two
  always_comb begin
    logic [LUT_IDX_W-1:0] idx;
    logic [8:0] mag;
    idx = phase_top[LUT_IDX_W-1:0];
    mag = 9'h000;
    if (phase_top[LUT_IDX_W]) begin
      idx = ~phase_top[LUT_IDX_W-1:0];
    end
    mag = quarter_cos(idx);
    // quadrants one and two are negative
    if (phase_top[LUT_IDX_W+1] ^ phase_top[LUT_IDX_W]) begin
      amplitude = 10'h200 - {1'b0, mag};
    end else begin
      amplitude = 10'h200 + {1'b0, mag};
    end
  end

endmodule

// ### design/dcs_core.sv
// synthesizer core: accumulator, cosine output and clock select
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dcs_core
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock selection pin
  input wire logic oscillator_mode_pin,
  // clock generation controls
  output logic oscillator_enable,
  output logic crystal_out_enable,
  output logic multiplier_enable,
  output logic [MULT_W-1:0] multiplier_value,
  output logic synthesis_clock_run,
  // converter sample
  output logic [SAMPLE_W-1:0] dac_sample
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  // whole module state, registered as one word
  typedef struct packed {
    logic [31:0] ctrl1_buf;   // software copy, first word
    logic [31:0] ctrl1_act;   // active copy, first word
    logic [31:0] ctrl2_buf;   // software copy, second word
    logic [31:0] ctrl2_act;   // active copy, second word
    logic [31:0] tune_buf;    // software copy, increment
    logic [31:0] tune_act;    // active increment
    logic [PHASE_W-1:0] phase; // accumulator
    logic [SAMPLE_W-1:0] sample; // converter sample
    logic [31:0] rdata;       // bus read data
    logic ready;              // bus ready
    logic slverr;             // bus error
    logic osc_en;             // oscillator enable
    logic xtal_en;            // crystal output buffer
    logic mult_en;            // multiplier powered
    logic [MULT_W-1:0] mult;  // multiplier factor
    logic run;                // synthesis clock gate
  } dcs_state_t;

  dcs_state_t r;       // current state
  dcs_state_t next_r;  // next state
  logic [SAMPLE_W-1:0] cos_amp; // cosine of current phase

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // register index from byte address
  function automatic logic [7:0] reg_index(
    input logic [ADDR_W-1:0] a
  );
    return a[9:2];
  endfunction

  // decoded address known to the map
  function automatic logic is_mapped(input logic [7:0] i);
    return (i == IDX_CTRL1) || (i == IDX_CTRL2) ||
           (i == IDX_TUNE) || (i == IDX_UPDATE) ||
           (i == IDX_STATUS) || (i == IDX_PHASE);
  endfunction

  // multiplier field of a second control word
  function automatic logic [MULT_W-1:0] mult_field(
    input logic [31:0] w
  );
    return w[MULT_LSB+MULT_W-1:MULT_LSB];
  endfunction

  // multiplier factor within the usable range
  function automatic logic mult_in_range(
    input logic [MULT_W-1:0] m
  );
    return (m >= MULT_MIN) && (m <= MULT_MAX);
  endfunction

  // ---------------------------------------------------------------
  // cosine map
  // ---------------------------------------------------------------
  // top phase bits select the table entry
  // cosine of phase
  dcs_cosine u_cosine (
    .phase_top (r.phase[PHASE_W-1:PHASE_W-LUT_IDX_W-2]),
    .amplitude (cos_amp)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // bus access, transfer strobe, accumulator, clock select
  always_comb begin
    logic [7:0] idx;
    logic access;
    logic wr;
    logic [MULT_W-1:0] m;
    logic [31:0] status;
    idx = reg_index(paddr);
    access = 1'b0;
    wr = 1'b0;
    m = '0;
    status = '0;
    next_r = r;

    // completion of an apb access
    access = psel && penable && r.ready;
    wr = access && pwrite;

    // writes land in the software copies
    if (wr) begin
      case (idx)
        IDX_CTRL1: begin
          next_r.ctrl1_buf = pwdata;
        end
        IDX_CTRL2: begin
          next_r.ctrl2_buf = pwdata;
        end
        IDX_TUNE: begin
          next_r.tune_buf = pwdata;
        end
        default: begin
          // update, read-only or unmapped: no software copy written
        end
      endcase
    end

    // transfer strobe moves software copies in
    // buffered copy transfer
    if (wr && (idx == IDX_UPDATE) && pwdata[UPDATE_BIT]) begin
      next_r.ctrl1_act = r.ctrl1_buf;
      next_r.ctrl2_act = r.ctrl2_buf;
      next_r.tune_act = r.tune_buf;
    end

    // accumulator only steps while the clock runs
    // clock gate holds
    if (r.run) begin
      if (r.ctrl1_act[CLR_PHASE_BIT]) begin
        next_r.phase = '0;
      end else begin
        next_r.phase = r.phase + r.tune_act;
      end
      next_r.sample = cos_amp;
    end

    // clock source selection from the active words and the mode pin
    // multiplier field
    m = mult_field(next_r.ctrl2_act);
    next_r.mult_en = mult_in_range(m);
    // bypass shows a factor of one
    next_r.mult = next_r.mult_en ? m : 5'h01;
    next_r.osc_en = oscillator_mode_pin;
    next_r.xtal_en = oscillator_mode_pin &&
                     next_r.ctrl2_act[XTAL_OUT_BIT];
    next_r.run = !next_r.ctrl1_act[CLK_OFF_BIT];

    // status word shows live core state
    status[ST_CLEAR] = r.ctrl1_act[CLR_PHASE_BIT];
    status[ST_MULT_EN] = r.mult_en;
    status[ST_RUN] = r.run;
    status[ST_OSC] = r.osc_en;
    status[ST_XTAL] = r.xtal_en;

    // setup cycle: load answer for the access phase
    next_r.ready = psel && !penable;
    if (psel && !penable) begin
      next_r.slverr = !is_mapped(idx);
      case (idx)
        IDX_CTRL1: begin
          next_r.rdata = r.ctrl1_buf;
        end
        IDX_CTRL2: begin
          next_r.rdata = r.ctrl2_buf;
        end
        IDX_TUNE: begin
          next_r.rdata = r.tune_buf;
        end
        IDX_STATUS: begin
          next_r.rdata = status;
        end
        IDX_PHASE: begin
          next_r.rdata = r.phase;
        end
        default: begin
          // update register and holes read zero
          next_r.rdata = '0;
        end
      endcase
    end else begin
      // answer lasts one cycle only
      next_r.slverr = 1'b0;
      next_r.rdata = '0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // synchronous reset to the defined initial state
  always_ff @(posedge clock) begin
    if (reset) begin
      r.ctrl1_buf <= CTRL1_BUF_RST;
      r.ctrl1_act <= CTRL1_ACT_RST;
      r.ctrl2_buf <= CTRL2_RST;
      r.ctrl2_act <= CTRL2_RST;
      r.tune_buf <= TUNE_RST;
      r.tune_act <= TUNE_RST;
      r.phase <= PHASE_RST;
      r.sample <= '0;
      r.rdata <= '0;
      r.ready <= 1'b0;
      r.slverr <= 1'b0;
      r.osc_en <= 1'b0;
      r.xtal_en <= 1'b0;
      r.mult_en <= 1'b0;
      r.mult <= 5'h01;
      r.run <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a state flip-flop
  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign oscillator_enable = r.osc_en;
  assign crystal_out_enable = r.xtal_en;
  assign multiplier_enable = r.mult_en;
  assign multiplier_value = r.mult;
  assign synthesis_clock_run = r.run;
  assign dac_sample = r.sample;

endmodule

// ### dv/dcs_core_asserts.sv
// concurrent checks on the synthesizer core ports
`timescale 1ns/1ps
module dcs_core_asserts
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // clock selection
  input wire logic oscillator_mode_pin,
  input wire logic oscillator_enable,
  input wire logic crystal_out_enable,
  input wire logic multiplier_enable,
  input wire logic [MULT_W-1:0] multiplier_value,
  input wire logic synthesis_clock_run,
  // converter sample
  input wire logic [SAMPLE_W-1:0] dac_sample
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  a_mult_in_range: assert property (
    multiplier_enable |-> multiplier_value inside {[5'h04:5'h14]})
    else $error("multiplier enabled out of range");
  a_bypass_value: assert property (
    !multiplier_enable |-> multiplier_value == 5'h01)
    else $error("bypass value wrong");
  a_osc_follows_pin: assert property (
    !$past(reset) |-> oscillator_enable == $past(oscillator_mode_pin))
    else $error("oscillator enable does not follow pin");
  a_xtal_needs_osc: assert property (
    crystal_out_enable |-> oscillator_enable)
    else $error("crystal output without oscillator");
  a_stop_holds_dac: assert property (
    !synthesis_clock_run && $past(!synthesis_clock_run) |->
    $stable(dac_sample))
    else $error("sample moved while clock stopped");
  a_reset_state: assert property (disable iff (1'b0)
    reset |=> !pready && dac_sample == 10'h000 && synthesis_clock_run &&
    multiplier_value == 5'h01 && !multiplier_enable)
    else $error("reset state wrong");
endmodule

bind dcs_core dcs_core_asserts i_dcs_core_asserts (.clock, .reset,
  .psel, .penable, .pready, .pslverr, .oscillator_mode_pin,
  .oscillator_enable, .crystal_out_enable, .multiplier_enable,
  .multiplier_value, .synthesis_clock_run, .dac_sample);

// ### dv/dcs_dac_model.sv
// converter output stage model latching each sample
`timescale 1ns/1ps
module dcs_dac_model
  import dcs_pkg::*;
(
  // clock
  input wire logic clock,
  // sample from the core
  input wire logic [SAMPLE_W-1:0] code,
  // code held on the converter
  output logic [SAMPLE_W-1:0] held
);
  // converter latches every cycle
  always_ff @(posedge clock) begin
    held <= code;
  end
endmodule

// ### dv/dcs_core_tb.sv
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
module dcs_core_tb
  import dcs_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic pin = 1'b1;
  logic [31:0] prdata, q, q2;
  logic pready, pslverr, e, oscillator_enable, crystal_out_enable;
  logic multiplier_enable, synthesis_clock_run;
  logic [MULT_W-1:0] multiplier_value;
  logic [SAMPLE_W-1:0] dac_sample, held;
  logic [4:0] ml [6] = '{5'h00, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1F};
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int t, t2;

  dcs_core i_dcs_core (.clock(clock), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_mode_pin(pin), .oscillator_enable(oscillator_enable),
    .crystal_out_enable(crystal_out_enable),
    .multiplier_enable(multiplier_enable),
    .multiplier_value(multiplier_value),
    .synthesis_clock_run(synthesis_clock_run), .dac_sample(dac_sample));
  dcs_dac_model i_dcs_dac_model (.clock(clock), .code(dac_sample),
    .held(held));

  // clock and cycle count
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task end_sim();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    output logic [31:0] rq, output logic re, output int rt);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // only a missing answer counts, not one on the last try
    if (pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
    rq = prdata;
    re = pslverr;
    rt = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, q, e, t);
  endtask
  task upd();
    wr(IDX_UPDATE, 32'h00000001);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task s_reset();
    chk("mult_val", 5'h01, multiplier_value);
    chk("run", 1'b1, synthesis_clock_run);
    apb(1'b0, IDX_CTRL2, 0, q, e, t);
    chk("ctrl2", CTRL2_RST, q);
    apb(1'b0, IDX_CTRL1, 0, q, e, t);
    chk("ctrl1", CTRL1_BUF_RST, q);
    wr(IDX_TUNE, 32'h00000001);
    apb(1'b0, IDX_STATUS, 0, q, e, t);
    chk("clear", 1'b1, q[ST_CLEAR]);
    apb(1'b0, IDX_PHASE, 0, q, e, t);
    chk("phase", PHASE_RST, q);
  endtask
  task s_accum(input logic [31:0] inc);
    wr(IDX_TUNE, inc);
    wr(IDX_CTRL1, 32'h00000000);
    upd();
    apb(1'b0, IDX_PHASE, 0, q, e, t);
    apb(1'b0, IDX_PHASE, 0, q2, e, t2);
    chk("phase_step", inc * 32'(t2 - t), q2 - q);
  endtask
  task s_clear();
    wr(IDX_CTRL1, 32'h00000400);
    upd();
    tick(4);
    apb(1'b0, IDX_PHASE, 0, q, e, t);
    chk("phase", 32'h00000000, q);
    chk("dac", 10'h3FF, held);
  endtask
  task s_mult();
    logic x;
    for (int i = 0; i < 6; i++) begin
      pin <= i[0];
      // factors only, no real clock above 400 MHz
      wr(IDX_CTRL2, {22'h0, !i[1], 1'b0, ml[i], 3'h0});
      upd();
      // settle before relying on the new setting
      tick(2);
      x = ml[i] >= MULT_MIN && ml[i] <= MULT_MAX;
      chk("mult_en", x, multiplier_enable);
      chk("mult_val", x ? ml[i] : 5'h01, multiplier_value);
      chk("osc_en", i[0], oscillator_enable);
      chk("xtal", i[0] & !i[1], crystal_out_enable);
      apb(1'b0, IDX_CTRL2, 0, q, e, t);
      chk("mult_field", ml[i], q[7:3]);
    end
  endtask
  task s_clk_off();
    wr(IDX_CTRL2, 32'h000000A0);
    wr(IDX_TUNE, 32'h00000003);
    wr(IDX_CTRL1, 32'h00000010);
    upd();
    tick(3);
    chk("run", 1'b0, synthesis_clock_run);
    chk("mult_val", 5'h14, multiplier_value);
    apb(1'b0, IDX_PHASE, 0, q, e, t);
    apb(1'b0, IDX_PHASE, 0, q2, e, t2);
    chk("phase_hold", q, q2);
    wr(IDX_CTRL1, 32'h00000000);
    upd();
    tick(3);
    chk("run", 1'b1, synthesis_clock_run);
  endtask
  task s_unmapped();
    apb(1'b0, 8'h03, 0, q, e, t);
    chk("pslverr", 1'b1, e);
    chk("rdata", 32'h00000000, q);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    tick(2);
    s_reset();
    s_accum(32'h00000001);
    s_accum(32'hFFFFFFFF);
    s_accum(32'h00000000);
    s_clear();
    s_mult();
    s_clk_off();
    s_unmapped();
    end_sim();
  end
endmodule
